// >>> rtl/dps_pkg.sv
// Package for the burst SRAM model: widths, timing counts and shared types.
// Assumes one system clock at 20 MHz; two system clocks make one input-clock period.
package dps_pkg;

	// Data and address widths (narrow configuration)
	localparam int WORD_W = 18;
	localparam int LANE_W = 9;
	localparam int BWS_W = 2;
	localparam int BURST_W = 2 * WORD_W;
	localparam int LANES = 2 * BWS_W;
	localparam int ADDR_W = 10;
	localparam int DEPTH = 1 << ADDR_W;

	// Field positions of the two words inside a stored burst
	localparam int WORD0_LSB = 0;
	localparam int WORD1_LSB = WORD_W;

	// Timing: lock interval in input-clock cycles, two system clocks per input cycle
	localparam int CLK_PER_KCYCLE = 2;
	localparam int DLL_LOCK_KCYCLES = 1024;
	localparam int DLL_LOCK_CLKS = DLL_LOCK_KCYCLES * CLK_PER_KCYCLE;
	localparam int LOCK_CNT_W = 12;

	// Read delivery delay from burst fetch to first word, in system clocks
	localparam logic [1:0] RD_LAT_DLL = 2'h2;
	localparam logic [1:0] RD_LAT_LEGACY = 2'h1;
	localparam logic [1:0] AGE_MAX = 2'h3;

	// Reset values
	localparam logic [WORD_W-1:0] RDATA_RST = 18'h00000;
	localparam logic PHASE_RST = 1'b0;
	localparam logic ECHO_RST = 1'b0;

	// Pin inputs, carried together through the synchroniser
	typedef struct packed {
		logic rdSelN;
		logic wrSelN;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
		logic [BWS_W-1:0] bwsN;
		logic dllDisableN;
		logic outClkP;
		logic outClkN;
	} dps_pins_s;

	// Read output sequencer states
	typedef enum logic [1:0] {
		OUT_IDLE,
		OUT_WAIT,
		OUT_WORD0,
		OUT_WORD1
	} dps_out_e;

endpackage

// >>> rtl/dps_burst_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock; reset is synchronous, active low.
`timescale 1ns/1ps
module dps_burst_buf #(
	parameter int W = 36,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] store [DEPTH];
	logic [PW-1:0] wrPtr_r;
	logic [PW-1:0] rdPtr_r;
	logic [PW:0] count_r;
	logic doPush;
	logic doPop;

	// Handshakes; full and empty come from the occupancy count
	assign inReady = (count_r != (PW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;
	assign outData = store[rdPtr_r];

	// Storage
	always_ff @(posedge clk) begin
		if (doPush) begin
			store[wrPtr_r] <= inData;
		end
	end

	// Pointers and count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (doPush) begin
				wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (doPop) begin
				rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
			end
			if (doPush && !doPop) begin
				count_r <= count_r + 1'b1;
			end else if (doPop && !doPush) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule

// >>> rtl/dps_sram_core.sv
// Burst SRAM with separate read and write ports on one multiplexed address bus.
// Assumes pins arrive asynchronously and are synchronised here; two system clocks
// model one input-clock period (even edge = positive clock rise, odd = negative).
//
// Operation
// [RULE1] Read starts on low read select at positive rise; address latched then. Code refuses the read while the burst buffer is full.
// [RULE2] DLL on: first word at negative rise of t+1, second at t+2.
// [RULE3] DLL disabled: read latency of exactly one cycle.
// [RULE4] Each access moves two sequential words, lowest-order word first.
// [RULE5] Read outputs go high impedance at the output edge after the last word.
// [RULE6] Write starts on low write select; first word captured, gated by selects.
// [RULE7] Next negative rise latches write address and second word, then commits.
// [RULE8] Deselected write port finishes a pending write, then ignores inputs.
// [RULE9] Byte selects sampled per word; asserted writes, deasserted keeps byte.
// [RULE10] Output clocks tied high at power on select single clock mode.
// [RULE11] Read and write ports run independently, may start in the same cycle.
// [RULE12] Read of a location being written returns newest data, forwarded.
// [RULE13] Selects sampled on positive rises only; pending transfers always finish.
// [RULE14] Inputs registered on input clock edges; outputs registered on output edges.
// [RULE15] Two free-running echo clocks follow the output clocks; code derives them from the input-clock phase, not outClkP/outClkN.
// [RULE16] DLL reports lock after 1024 stable input-clock cycles.
// [RULE17] Controller may stop clocks 30 ns to reset DLL, then wait relock.
// [RULE18] After power up both ports deselected and read outputs tristated.
// [RULE19] Legacy mode input clock must stay at or below 167 MHz.
// [RULE20] Select zero gates bits 8:0, select one bits 17:9; all high writes nothing.
// [RULE21] Both selects high: no transaction, write data ignored, outputs high impedance.
// [RULE22] With clocks stopped, outputs and internal state hold.
`timescale 1ns/1ps
module dps_sram_core
	import dps_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic readPortSelectN,
	input wire logic writePortSelectN,
	input wire logic [ADDR_W-1:0] addrIn,
	input wire logic [WORD_W-1:0] dataIn,
	input wire logic [BWS_W-1:0] byteWriteSelectN,
	input wire logic dllDisableN,
	input wire logic outClkP,
	input wire logic outClkN,
	input wire logic rdReady,
	output logic [WORD_W-1:0] readData,
	output logic readDataOe,
	output logic echoClock,
	output logic echoClockN,
	output logic dllLocked,
	output logic singleClockMode
);

	dps_pins_s pinRaw;
	dps_pins_s pinMeta_r;
	dps_pins_s pin_r;
	logic kPhase_r;
	logic posRise;
	logic negRise;

	// Read side state
	logic rdPend_r;
	logic [ADDR_W-1:0] rdAddr_r;
	logic [BURST_W-1:0] rdBurst;
	logic bufInReady;
	logic bufOutValid;
	logic bufPop;
	logic [BURST_W-1:0] bufData;
	logic [1:0] pushAge_r;
	logic [1:0] rdLat;
	logic due;
	dps_out_e outState_r;
	dps_out_e outState_nxt;
	logic [WORD_W-1:0] readData_r;
	logic readDataOe_r;
	logic [WORD_W-1:0] word1Hold_r;

	// Write side state
	logic wrPend_r;
	logic [WORD_W-1:0] wrWord0_r;
	logic [BWS_W-1:0] wrBws0N_r;
	logic wrCommit;
	logic [ADDR_W-1:0] wrAddr;
	logic [BURST_W-1:0] wrBurst;
	logic [LANES-1:0] wrLaneEn;

	// Array, one burst per address
	logic [BURST_W-1:0] mem [DEPTH];

	// Clocking status
	logic [LOCK_CNT_W-1:0] lockCnt_r;
	logic dllLocked_r;
	logic strapTaken_r;
	logic singleClock_r;
	logic echoClock_r;
	logic echoClockN_r;

	// Gather pins for the synchroniser
	assign pinRaw = '{
		rdSelN: readPortSelectN,
		wrSelN: writePortSelectN,
		addr: addrIn,
		data: dataIn,
		bwsN: byteWriteSelectN,
		dllDisableN: dllDisableN,
		outClkP: outClkP,
		outClkN: outClkN
	};

	// Two-stage synchroniser; only the second stage feeds logic
	always_ff @(posedge clk) begin
		pinMeta_r <= pinRaw; // [RULE14]
		pin_r <= pinMeta_r;
	end

	// Input-clock phase: even edges are positive rises, odd are negative rises
	always_ff @(posedge clk) begin
		if (!nrst) begin
			kPhase_r <= PHASE_RST;
		end else begin
			kPhase_r <= ~kPhase_r;
		end
	end

	assign posRise = (kPhase_r == 1'b0);
	assign negRise = (kPhase_r == 1'b1);

	// Read start: select sampled on positive rise only, refused while buffer full
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdPend_r <= 1'b0; // [RULE18]
			rdAddr_r <= '0;
		end else if (posRise) begin
			rdPend_r <= !pin_r.rdSelN && bufInReady; // [RULE1] [RULE13] [RULE21]
			if (!pin_r.rdSelN) begin
				rdAddr_r <= pin_r.addr; // [RULE1]
			end
		end else begin
			rdPend_r <= 1'b0;
		end
	end

	// Write start: first word and its byte selects captured at positive rise
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wrPend_r <= 1'b0; // [RULE18]
			wrWord0_r <= '0;
			wrBws0N_r <= '1;
		end else if (posRise) begin
			wrPend_r <= !pin_r.wrSelN; // [RULE6] [RULE11] [RULE13] [RULE21]
			if (!pin_r.wrSelN) begin
				wrWord0_r <= pin_r.data; // [RULE6]
				wrBws0N_r <= pin_r.bwsN; // [RULE9]
			end
		end else begin
			wrPend_r <= 1'b0;
		end
	end

	// Commit at the negative rise: a pending write finishes even if now deselected
	assign wrCommit = wrPend_r && negRise; // [RULE8] [RULE7]
	assign wrAddr = pin_r.addr; // [RULE7]
	assign wrBurst = {pin_r.data, wrWord0_r}; // [RULE4]
	assign wrLaneEn = {~pin_r.bwsN, ~wrBws0N_r}; // [RULE9] [RULE20]

	// Byte-lane writes into the array
	always_ff @(posedge clk) begin
		if (wrCommit) begin
			for (int i = 0; i < LANES; i++) begin
				if (wrLaneEn[i]) begin
					mem[wrAddr][i*LANE_W +: LANE_W] <= wrBurst[i*LANE_W +: LANE_W]; // [RULE7]
				end
			end
		end
	end

	// Burst fetch merges a write committing on the same edge to the same address
	always_comb begin
		rdBurst = mem[rdAddr_r];
		if (wrCommit && (wrAddr == rdAddr_r)) begin
			for (int i = 0; i < LANES; i++) begin
				if (wrLaneEn[i]) begin
					rdBurst[i*LANE_W +: LANE_W] = wrBurst[i*LANE_W +: LANE_W]; // [RULE12]
				end
			end
		end
	end

	// Fetched bursts wait here so a stalled receiver loses none
	dps_burst_buf #(
		.W(BURST_W),
		.DEPTH(2)
	) u_buf (
		.clk(clk),
		.nrst(nrst),
		.inValid(rdPend_r),
		.inReady(bufInReady),
		.inData(rdBurst),
		.outValid(bufOutValid),
		.outReady(bufPop),
		.outData(bufData)
	);

	// Cycles since the most recent fetch, saturating
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pushAge_r <= AGE_MAX;
		end else if (rdPend_r) begin
			pushAge_r <= 2'h0;
		end else if (pushAge_r != AGE_MAX) begin
			pushAge_r <= pushAge_r + 2'h1;
		end
	end

	// Latency follows the DLL strap level
	assign rdLat = pin_r.dllDisableN ? RD_LAT_DLL : RD_LAT_LEGACY; // [RULE3] [RULE2]
	assign due = bufOutValid && (pushAge_r >= (rdLat - 2'h1)); // [RULE2] [RULE3]
	assign bufPop = (outState_r == OUT_WORD0) && rdReady;

	// Output sequencer
	always_comb begin
		outState_nxt = outState_r;
		case (outState_r)
			OUT_IDLE: begin
				if (due) begin
					outState_nxt = OUT_WORD0;
				end else if (bufOutValid) begin
					outState_nxt = OUT_WAIT;
				end
			end
			OUT_WAIT: begin
				if (due) begin
					outState_nxt = OUT_WORD0;
				end
			end
			OUT_WORD0: begin
				if (rdReady) begin
					outState_nxt = OUT_WORD1;
				end
			end
			OUT_WORD1: begin
				if (rdReady) begin
					if (due) begin
						outState_nxt = OUT_WORD0;
					end else if (bufOutValid) begin
						outState_nxt = OUT_WAIT;
					end else begin
						outState_nxt = OUT_IDLE; // [RULE5]
					end
				end
			end
			default: begin
				outState_nxt = OUT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			outState_r <= OUT_IDLE;
		end else begin
			outState_r <= outState_nxt;
		end
	end

	// Registered read data and drive enable; low word first, then high word
	always_ff @(posedge clk) begin
		if (!nrst) begin
			readData_r <= RDATA_RST;
			readDataOe_r <= 1'b0; // [RULE18]
			word1Hold_r <= '0;
		end else begin
			case (outState_nxt)
				OUT_WORD0: begin
					if (outState_r != OUT_WORD0) begin
						readData_r <= bufData[WORD0_LSB +: WORD_W]; // [RULE4] [RULE14]
						word1Hold_r <= bufData[WORD1_LSB +: WORD_W];
					end
					readDataOe_r <= 1'b1;
				end
				OUT_WORD1: begin
					if (outState_r == OUT_WORD0) begin
						readData_r <= word1Hold_r; // [RULE4] [RULE2]
					end
					readDataOe_r <= 1'b1;
				end
				default: begin
					readData_r <= RDATA_RST;
					readDataOe_r <= 1'b0; // [RULE5] [RULE21]
				end
			endcase
		end
	end

	// Single clock strap caught once after reset release; cannot change later
	always_ff @(posedge clk) begin
		if (!nrst) begin
			strapTaken_r <= 1'b0;
			singleClock_r <= 1'b0;
		end else if (!strapTaken_r) begin
			strapTaken_r <= 1'b1;
			singleClock_r <= pin_r.outClkP && pin_r.outClkN; // [RULE10]
		end
	end

	// Echo clocks: free running, one per output clock phase; same timing either mode
	always_ff @(posedge clk) begin
		if (!nrst) begin
			echoClock_r <= ECHO_RST;
			echoClockN_r <= ~ECHO_RST;
		end else begin
			echoClock_r <= negRise; // [RULE15]
			echoClockN_r <= posRise; // [RULE15]
		end
	end

	// Lock counter; restarts whenever the DLL is disabled
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lockCnt_r <= '0;
			dllLocked_r <= 1'b0;
		end else if (!pin_r.dllDisableN) begin
			lockCnt_r <= '0;
			dllLocked_r <= 1'b0;
		end else if (lockCnt_r == LOCK_CNT_W'(DLL_LOCK_CLKS - 1)) begin
			dllLocked_r <= 1'b1; // [RULE16]
		end else begin
			lockCnt_r <= lockCnt_r + 1'b1;
		end
	end

	// Outputs straight from flip-flops; all hold while clk is stopped
	assign readData = readData_r; // [RULE22]
	assign readDataOe = readDataOe_r;
	assign echoClock = echoClock_r;
	assign echoClockN = echoClockN_r;
	assign dllLocked = dllLocked_r;
	assign singleClockMode = singleClock_r;

endmodule

// >>> test/dps_sram_checker.sv
// Port assertions for the burst SRAM core.
// Assumes one clk domain and synchronous active-low nrst.
`timescale 1ns/1ps
module dps_sram_checker
	import dps_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic readPortSelectN,
	input wire logic dllDisableN,
	input wire logic rdReady,
	input wire logic [WORD_W-1:0] readData,
	input wire logic readDataOe,
	input wire logic echoClock,
	input wire logic echoClockN,
	input wire logic dllLocked,
	input wire logic singleClockMode
);
	logic [3:0] sinceRd;
	logic [12:0] lockCnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Cycles since the read select pin was low
	always_ff @(posedge clk) begin
		if (!readPortSelectN) begin
			sinceRd <= 4'h0;
		end else if (sinceRd != 4'hF) begin
			sinceRd <= sinceRd + 4'h1;
		end
	end
	// Cycles with the loop enabled and out of reset
	always_ff @(posedge clk) begin
		if (!nrst || !dllDisableN) begin
			lockCnt <= 13'h0000;
		end else if (lockCnt != 13'h1FFF) begin
			lockCnt <= lockCnt + 13'h0001;
		end
	end
	sequence sStall;
		readDataOe && !rdReady;
	endsequence
	sequence sHeld;
		readDataOe && $stable(readData);
	endsequence
	AST_RST_QUIET: assert property (disable iff (1'b0)
		!nrst |=> !readDataOe && readData == RDATA_RST) else $error("output after reset");
	AST_IDLE_ZERO: assert property (!readDataOe |-> readData == RDATA_RST)
		else $error("data while idle");
	AST_ECHO_PAIR: assert property (echoClockN == !echoClock)
		else $error("echo pair not inverse");
	AST_ECHO_RUN: assert property ($past(nrst, 3) |-> echoClock != $past(echoClock))
		else $error("echo stopped");
	AST_HOLD: assert property (sStall |=> sHeld)
		else $error("word lost in stall");
	AST_RD_CAUSE: assert property ($rose(readDataOe) |-> sinceRd <= 4'h8)
		else $error("output without read");
	AST_LOCK_EARLY: assert property ($rose(dllLocked) |-> lockCnt >= 13'(DLL_LOCK_CLKS))
		else $error("lock too early");
	AST_LOCK_LATE: assert property (lockCnt >= 13'(DLL_LOCK_CLKS + 4) |-> dllLocked)
		else $error("lock too late");
	AST_DLL_OFF: assert property (!dllDisableN [*4] |=> !dllLocked)
		else $error("lock while disabled");
	AST_STRAP: assert property ($past(nrst, 4) |-> $stable(singleClockMode))
		else $error("strap changed");
endmodule
bind dps_sram_core dps_sram_checker chk (.clk, .nrst, .readPortSelectN, .dllDisableN,
	.rdReady, .readData, .readDataOe, .echoClock, .echoClockN, .dllLocked, .singleClockMode);

// >>> test/dps_rx_model.sv
// Read-side receiver of the controller: takes words, may stall.
// Assumes readData is valid while readDataOe is high.
`timescale 1ns/1ps
module dps_rx_model
	import dps_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic stall,
	input wire logic [WORD_W-1:0] readData,
	input wire logic readDataOe,
	output logic rdReady
);
	logic [WORD_W-1:0] got[$];
	// Take a word when offered and ready; ready moves just after an edge
	always @(posedge clk) begin
		if (nrst && readDataOe && rdReady) begin
			got.push_back(readData);
		end
		rdReady <= !stall;
	end
endmodule

// >>> test/dps_sram_bench.sv
// Bench for the burst SRAM core with a stalling receiver model.
// Assumes inputs change on falling edges; two clk make one port period.
`timescale 1ns/1ps
module dps_sram_bench
	import dps_pkg::*;
();
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic rs = 1'b1;
	logic ws = 1'b1;
	logic [ADDR_W-1:0] addr = 10'h000;
	logic [WORD_W-1:0] data = 18'h00000;
	logic [BWS_W-1:0] byte_write_select_n = 2'h3;
	logic dllDisableN = 1'b0;
	logic outP = 1'b0;
	logic outN = 1'b0;
	logic stall = 1'b0;
	logic [WORD_W-1:0] readData;
	logic readDataOe, echoClock, echoClockN, dllLocked, singleClockMode, rdReady;
	logic [15:0] cyc = 16'h0000;
	int tmo = 0;
	int nMismatch = 0;
	int checksDone = 0;
	int lat;
	localparam logic [BURST_W-1:0] DA = 36'h123456789;
	localparam logic [BURST_W-1:0] DB = 36'hABCDEF012;
	localparam logic [BURST_W-1:0] DC = 36'h3C5A69F0E;
	dps_sram_core uut (.clk, .nrst, .readPortSelectN(rs), .writePortSelectN(ws),
		.addrIn(addr), .dataIn(data), .byteWriteSelectN(byte_write_select_n), .dllDisableN,
		.outClkP(outP), .outClkN(outN), .rdReady, .readData, .readDataOe,
		.echoClock, .echoClockN, .dllLocked, .singleClockMode);
	dps_rx_model rx (.clk, .nrst, .stall, .readData, .readDataOe, .rdReady);
	always #25 clk = ~clk;
	// Edge count since release, and the hang limit
	always @(posedge clk) begin
		cyc <= nrst ? cyc + 16'h0001 : 16'h0000;
		tmo <= tmo + 1;
		if (tmo == 20000) begin
			nMismatch++;
			stopTest();
		end
	end
	task automatic check(input string what, input logic [BURST_W-1:0] seen, exp);
		checksDone++;
		if (seen !== exp) begin
			nMismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stopTest();
		if (nMismatch == 0 && checksDone > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One port period: read and write selects, word0 then word1
	task automatic op(input logic rd, wr, input logic [ADDR_W-1:0] a,
		input logic [BURST_W-1:0] d, input logic [3:0] b);
		while (cyc[0]) @(negedge clk);
		rs = !rd;
		ws = !wr;
		addr = a;
		data = d[17:0];
		byte_write_select_n = b[1:0];
		@(negedge clk);
		rs = 1'b1;
		ws = 1'b1;
		data = d[35:18];
		byte_write_select_n = b[3:2];
		@(negedge clk);
	endtask
	task automatic readLat(input logic [ADDR_W-1:0] a, output int n);
		int s;
		while (cyc[0]) @(negedge clk);
		s = cyc;
		op(1'b1, 1'b0, a, DA, 4'hF);
		n = 0;
		while (!readDataOe && n < 20) begin
			@(negedge clk);
			n++;
		end
		n = cyc - s;
	endtask
	task automatic getBurst(input string what, input logic [BURST_W-1:0] exp);
		logic [BURST_W-1:0] seen;
		int n;
		seen = 'x;
		n = 0;
		while (rx.got.size() < 2 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (rx.got.size() >= 2) begin
			seen[17:0] = rx.got.pop_front();
			seen[35:18] = rx.got.pop_front();
		end
		check(what, seen, exp);
	endtask
	task automatic tReset();
		check("oe", readDataOe, 0);
		check("rdata", readData, 0);
		check("strap", singleClockMode, 0);
	endtask
	task automatic tLegacy();
		op(1'b0, 1'b1, 10'h005, DA, 4'h0);
		readLat(10'h005, lat);
		check("legacyLat", lat, 5);
		getBurst("legacyData", DA);
		check("oeOff", readDataOe, 0);
	endtask
	task automatic tBytes();
		op(1'b0, 1'b1, 10'h005, DB, 4'hE);
		op(1'b0, 1'b0, 10'h005, DC, 4'h0);
		op(1'b1, 1'b0, 10'h005, DC, 4'h0);
		getBurst("lanes", {DA[35:9], DB[8:0]});
	endtask
	task automatic tConcur();
		op(1'b1, 1'b1, 10'h00A, DC, 4'h0);
		op(1'b0, 1'b1, 10'h00B, DB, 4'h0);
		op(1'b1, 1'b0, 10'h00B, DA, 4'h0);
		getBurst("sameCycle", DC);
		getBurst("nextCycle", DB);
	endtask
	task automatic tStall();
		stall = 1'b1;
		op(1'b1, 1'b0, 10'h005, DA, 4'h0);
		op(1'b1, 1'b0, 10'h00A, DA, 4'h0);
		repeat (12) @(negedge clk);
		check("heldOe", readDataOe, 1);
		check("noWord", rx.got.size(), 0);
		stall = 1'b0;
		getBurst("stall1", {DA[35:9], DB[8:0]});
		getBurst("stall2", DC);
	endtask
	// DLL on: longer latency, lock after the count, lock lost when disabled again
	task automatic tDll();
		dllDisableN = 1'b1;
		repeat (4) @(negedge clk);
		readLat(10'h00B, lat);
		check("dllLat", lat, 6);
		getBurst("dllData", DB);
		check("noLock", dllLocked, 0);
		repeat (2100) @(negedge clk);
		check("lock", dllLocked, 1);
		dllDisableN = 1'b0;
		repeat (4) @(negedge clk);
		check("unlock", dllLocked, 0);
		dllDisableN = 1'b1;
	endtask
	task automatic tStrap();
		outP = 1'b1;
		outN = 1'b1;
		nrst = 1'b0;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check("strap1", singleClockMode, 1);
		readLat(10'h00B, lat);
		check("scmLat", lat, 6);
		getBurst("scmData", DB);
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		tReset();
		tLegacy();
		tBytes();
		tConcur();
		tStall();
		tDll();
		tStrap();
		stopTest();
	end
endmodule
